// ===== hw/synth_control_regs_two_three.sv
// Function
// R1: low three bits route word to register
// R2: noise field: 00 low-noise, 10/11 low-spur
// R3: pin selector: three bits here, msb elsewhere
// R4: selector codes 0000-0100: z, high, low, dividers
// R5: codes 0101-0111, 1100: locks, sync, readback
// R6: bit 25 enables reference doubler
// R7: bit 24 enables reference halving
// R8: reference divide staged until register 0 write
// R9: bit 13 turns buffered update on
// R10: pump current code staged, current one plus code
// R11: lock function and lock window select bits
// R12: bit 6 detector polarity, positive by default
// R13: bit 4 pump high-z, bit 5 power down
// R14: bit 3 holds counters in reset
// R15: manual oscillator select only when auto disabled
// R16: bit 25 disables automatic oscillator selection
// R17: bit 24 enables auto-select temperature compensation
// R18: bit 18 enables cycle-slip reduction
// R19: bit 17 delays lock feeding mute function; the code applies the delay only in mute-delay divider mode
// R20: divider mode: mute delay, fast-lock, phase adjust
// R21: twelve-bit timing divider value, zero unused
// R22: output divider staged only when buffered update
// R23: host programs everything twice, 20ms apart
// R24: mute-until-locked silences outputs until lock
// R25: host avoids reserved codes and reserved bits
`timescale 1ns/100ps
`default_nettype none

module synth_control_regs_two_three
(
	// clock and reset
	input  wire logic                      mclk_in,
	input  wire logic                      rst_n_in,
	// serial programming port
	input  wire logic                      ser_clk_in,
	input  wire logic                      ser_data_in,
	input  wire logic                      ser_load_in,
	// multiplexed pin
	input  wire logic                      mux_pin_in,
	output logic                           mux_pin_out,
	output logic                           mux_pin_oe_out,
	// device-side sources
	input  wire logic                      mux_msb_in,
	input  wire logic                      ref_div_in,
	input  wire logic                      fb_div_in,
	input  wire logic                      analog_lock_in,
	input  wire logic                      lock_indication_in,
	input  wire logic [31:0]               readback_word_in,
	// controls
	output synth_ctrl_pkg::ref_ctrl_t      ref_ctrl_out,
	output synth_ctrl_pkg::osc_ctrl_t      osc_ctrl_out,
	output logic [2:0]                     out_div_ratio_out,
	output logic                           mute_until_locked_out,
	output logic                           rf_mute_out,
	output logic                           timing_tick_out,
	output logic                           sync_out
);
	import synth_ctrl_pkg::*;

	// ****************************************************************
	// serial capture
	// ****************************************************************
	logic              sclk_q_r;
	logic              load_q_r;
	logic [WORD_W-1:0] shift_r;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              load_rise;
	logic              wr_reg0;
	logic              wr_reg2;
	logic              wr_reg3;
	logic              wr_reg4;

	assign sclk_rise = ser_clk_in & ~sclk_q_r;
	assign sclk_fall = ~ser_clk_in & sclk_q_r;
	assign load_rise = ser_load_in & ~load_q_r;

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			sclk_q_r <= 1'b0;
			load_q_r <= 1'b0;
		end
		else
		begin
			sclk_q_r <= ser_clk_in;
			load_q_r <= ser_load_in;
		end
	end

	// msb first; bits clocked while load is high are ignored
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			shift_r <= 32'h00000000;
		else if (sclk_rise && !ser_load_in)
			shift_r <= {shift_r[WORD_W-2:0], ser_data_in};
	end

	// words for registers 1, 5 and above are dropped here
	always_comb
	begin
		wr_reg0 = 1'b0;
		wr_reg2 = 1'b0;
		wr_reg3 = 1'b0;
		wr_reg4 = 1'b0;
		if (!load_rise)
			wr_reg0 = 1'b0;
		else if (shift_r[ADDR_W-1:0] == ADDR_REG0)
			wr_reg0 = 1'b1;
		else if (shift_r[ADDR_W-1:0] == ADDR_REG2) // R1
			wr_reg2 = 1'b1;
		else if (shift_r[ADDR_W-1:0] == ADDR_REG3) // R1
			wr_reg3 = 1'b1;
		else if (shift_r[ADDR_W-1:0] == ADDR_REG4)
			wr_reg4 = 1'b1;
	end

	// ****************************************************************
	// register words and double buffers
	// ****************************************************************
	ref_word_t  ref_word_r;
	osc_word_t  osc_word_r;
	logic [9:0] ref_divide_act_r;
	logic [3:0] pump_code_act_r;
	logic [2:0] out_div_stage_r;
	logic [2:0] out_div_act_r;
	logic       mute_lock_r;

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			ref_word_r <= REF_WORD_RESET;
		else if (wr_reg2)
			ref_word_r <= ref_word_t'(shift_r);
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			osc_word_r <= OSC_WORD_RESET;
		else if (wr_reg3)
			osc_word_r <= osc_word_t'(shift_r);
	end

	// a staged zero divide is unused, so the old divide stays
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			ref_divide_act_r <= REF_WORD_RESET.ref_divide;
			pump_code_act_r <= REF_WORD_RESET.pump_current_code;
		end
		else if (wr_reg0)
		begin
			if (ref_word_r.ref_divide != 10'h000)
				ref_divide_act_r <= ref_word_r.ref_divide; // R8
			pump_code_act_r <= ref_word_r.pump_current_code; // R10
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			out_div_stage_r <= OUT_DIV_RESET;
			out_div_act_r <= OUT_DIV_RESET;
			mute_lock_r <= MUTE_LOCK_RESET;
		end
		else if (wr_reg4)
		begin
			out_div_stage_r <= shift_r[OUT_DIV_MSB:OUT_DIV_LSB];
			if (!ref_word_r.buffered_update_enable) // R9 R22
				out_div_act_r <= shift_r[OUT_DIV_MSB:OUT_DIV_LSB];
			mute_lock_r <= shift_r[MUTE_LOCK_BIT];
		end
		// a held value is released even if buffering was switched off since;
		// unbuffered writes keep stage and active equal, so this is harmless then
		else if (wr_reg0) // R22
			out_div_act_r <= out_div_stage_r;
	end

	// ****************************************************************
	// decoded controls
	// ****************************************************************
	ref_ctrl_t ref_ctrl_nxt;
	osc_ctrl_t osc_ctrl_nxt;

	always_comb
	begin
		ref_ctrl_nxt.lock_speed_select = ref_word_r.lock_speed_select;
		// reserved noise code keeps the quiet setting
		case (ref_word_r.modulator_noise_mode) // R2
			NOISE_CODE_SPUR1: ref_ctrl_nxt.noise_mode = NOISE_SPUR_ONE;
			NOISE_CODE_SPUR2: ref_ctrl_nxt.noise_mode = NOISE_SPUR_TWO;
			default:          ref_ctrl_nxt.noise_mode = NOISE_LOW;
		endcase
		ref_ctrl_nxt.reference_doubler_enable = ref_word_r.reference_doubler_enable; // R6
		ref_ctrl_nxt.reference_halve_enable = ref_word_r.reference_halve_enable; // R7
		ref_ctrl_nxt.ref_divide = ref_divide_act_r; // R8
		ref_ctrl_nxt.buffered_update_enable = ref_word_r.buffered_update_enable; // R9
		ref_ctrl_nxt.pump_current_code = pump_code_act_r; // R10
		ref_ctrl_nxt.pump_current_units = {1'b0, pump_code_act_r} + 5'h01; // R10
		ref_ctrl_nxt.lock_function_select = ref_word_r.lock_function_select; // R11
		ref_ctrl_nxt.lock_window_select = ref_word_r.lock_window_select; // R11
		ref_ctrl_nxt.detector_polarity = ref_word_r.detector_polarity; // R12
		ref_ctrl_nxt.device_power_down = ref_word_r.device_power_down; // R13
		ref_ctrl_nxt.pump_high_z = ref_word_r.pump_high_z; // R13
		ref_ctrl_nxt.counter_reset = ref_word_r.counter_reset; // R14
	end

	always_comb
	begin
		osc_ctrl_nxt.manual_osc_select = osc_word_r.osc_select; // R15
		osc_ctrl_nxt.manual_osc_active = osc_word_r.auto_select_disable; // R15
		osc_ctrl_nxt.auto_oscillator_select = ~osc_word_r.auto_select_disable; // R16
		osc_ctrl_nxt.auto_select_temp_comp = osc_word_r.auto_select_temp_comp; // R17
		osc_ctrl_nxt.cycle_slip_reduce = osc_word_r.cycle_slip_reduce; // R18
		osc_ctrl_nxt.lock_indicate_delay = osc_word_r.lock_indicate_delay; // R19
		case (osc_word_r.timing_divider_mode) // R20
			TMODE_CODE_MUTE:  osc_ctrl_nxt.timing_divider_mode = TMODE_MUTE_DELAY;
			TMODE_CODE_FAST:  osc_ctrl_nxt.timing_divider_mode = TMODE_FAST_LOCK;
			TMODE_CODE_PHASE: osc_ctrl_nxt.timing_divider_mode = TMODE_PHASE_ADJ;
			default:          osc_ctrl_nxt.timing_divider_mode = TMODE_OFF;
		endcase
		osc_ctrl_nxt.timing_divider_value = osc_word_r.timing_divider_value; // R21
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			ref_ctrl_out <= '0;
			osc_ctrl_out <= '0;
			out_div_ratio_out <= OUT_DIV_RESET;
			mute_until_locked_out <= MUTE_LOCK_RESET;
		end
		else
		begin
			ref_ctrl_out <= ref_ctrl_nxt;
			osc_ctrl_out <= osc_ctrl_nxt;
			out_div_ratio_out <= out_div_act_r;
			mute_until_locked_out <= mute_lock_r;
		end
	end

	// ****************************************************************
	// timing divider and lock qualification
	// ****************************************************************
	logic       tick;
	logic [7:0] lock_count_r;
	logic       delay_active;
	logic       lock_qualified;

	timing_divider u_timing_divider
	(
		.mclk_in   (mclk_in),
		.rst_n_in  (rst_n_in),
		.enable_in (osc_ctrl_nxt.timing_divider_mode != TMODE_OFF), // R20
		.divide_in (osc_word_r.timing_divider_value), // R21
		.tick_out  (tick)
	);

	assign delay_active = osc_word_r.lock_indicate_delay &&
		(osc_ctrl_nxt.timing_divider_mode == TMODE_MUTE_DELAY);

	// lock must hold for a whole run of ticks, so with the lock delay active a flickering lock never unmutes
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			lock_count_r <= 8'h00;
		else if (!lock_indication_in)
			lock_count_r <= 8'h00;
		else if (tick && lock_count_r != LOCK_DELAY_TICKS)
			lock_count_r <= lock_count_r + 8'h01;
	end

	assign lock_qualified = delay_active ? (lock_count_r == LOCK_DELAY_TICKS) : lock_indication_in; // R19

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			rf_mute_out <= 1'b0;
			timing_tick_out <= 1'b0;
		end
		else
		begin
			rf_mute_out <= mute_lock_r & ~lock_qualified; // R24
			timing_tick_out <= tick;
		end
	end

	// ****************************************************************
	// multiplexed pin
	// ****************************************************************
	logic [3:0]        mux_sel;
	logic              fb_q_r;
	logic              fb_half_r;
	logic [WORD_W-1:0] rb_shift_r;
	logic              mux_pin_nxt;
	logic              mux_oe_nxt;

	assign mux_sel = {mux_msb_in, ref_word_r.pin_select_low}; // R3

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			fb_q_r <= 1'b0;
			fb_half_r <= 1'b0;
		end
		else
		begin
			fb_q_r <= fb_div_in;
			if (fb_div_in && !fb_q_r)
				fb_half_r <= ~fb_half_r;
		end
	end

	// readback word is latched at load and shifted out on falling serial clock
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			rb_shift_r <= 32'h00000000;
		else if (load_rise && mux_sel == MUX_READBACK) // R5
			rb_shift_r <= readback_word_in;
		else if (sclk_fall && !ser_load_in)
			rb_shift_r <= {rb_shift_r[WORD_W-2:0], 1'b0};
	end

	always_comb
	begin
		mux_pin_nxt = 1'b0;
		mux_oe_nxt = 1'b1;
		case (mux_sel)
			MUX_HIGH_Z:       mux_oe_nxt = 1'b0; // R4
			MUX_DRIVE_HIGH:   mux_pin_nxt = 1'b1; // R4
			MUX_DRIVE_LOW:    mux_pin_nxt = 1'b0; // R4
			MUX_REF_DIV:      mux_pin_nxt = ref_div_in; // R4
			MUX_FB_HALF:      mux_pin_nxt = fb_half_r; // R4
			MUX_ANALOG_LOCK:  mux_pin_nxt = analog_lock_in; // R5
			MUX_DIGITAL_LOCK: mux_pin_nxt = lock_indication_in; // R5
			MUX_SYNC_IN:      mux_oe_nxt = 1'b0; // R5
			MUX_READBACK:     mux_pin_nxt = rb_shift_r[WORD_W-1]; // R5
			// reserved codes leave the pin undriven
			default:          mux_oe_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			mux_pin_out <= 1'b0;
			mux_pin_oe_out <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			mux_pin_out <= mux_pin_nxt;
			mux_pin_oe_out <= mux_oe_nxt;
			sync_out <= (mux_sel == MUX_SYNC_IN) & mux_pin_in; // R5
		end
	end

endmodule : synth_control_regs_two_three

`default_nettype wire

// ===== hw/synth_ctrl_pkg.sv
package synth_ctrl_pkg;

	// ****************************************************************
	// word framing
	// ****************************************************************
	localparam int WORD_W = 32;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] ADDR_REG0 = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_REG2 = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_REG3 = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_REG4 = 3'h4;

	// ****************************************************************
	// register 4 fields that this block tracks
	// ****************************************************************
	localparam int OUT_DIV_MSB = 22;
	localparam int OUT_DIV_LSB = 20;
	localparam int MUTE_LOCK_BIT = 10;
	localparam logic [2:0] OUT_DIV_RESET = 3'h0;
	localparam logic MUTE_LOCK_RESET = 1'b0;

	// ****************************************************************
	// field codes
	// ****************************************************************
	localparam logic [1:0] NOISE_CODE_LOW = 2'h0;
	localparam logic [1:0] NOISE_CODE_SPUR1 = 2'h2;
	localparam logic [1:0] NOISE_CODE_SPUR2 = 2'h3;
	localparam logic [1:0] TMODE_CODE_MUTE = 2'h0;
	localparam logic [1:0] TMODE_CODE_FAST = 2'h1;
	localparam logic [1:0] TMODE_CODE_PHASE = 2'h2;
	localparam logic [3:0] MUX_HIGH_Z = 4'h0;
	localparam logic [3:0] MUX_DRIVE_HIGH = 4'h1;
	localparam logic [3:0] MUX_DRIVE_LOW = 4'h2;
	localparam logic [3:0] MUX_REF_DIV = 4'h3;
	localparam logic [3:0] MUX_FB_HALF = 4'h4;
	localparam logic [3:0] MUX_ANALOG_LOCK = 4'h5;
	localparam logic [3:0] MUX_DIGITAL_LOCK = 4'h6;
	localparam logic [3:0] MUX_SYNC_IN = 4'h7;
	localparam logic [3:0] MUX_READBACK = 4'hC;

	// lock qualification length in timing-divider ticks
	localparam logic [7:0] LOCK_DELAY_TICKS = 8'h10;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {NOISE_LOW, NOISE_SPUR_ONE, NOISE_SPUR_TWO} noise_mode_t;
	typedef enum logic [1:0] {TMODE_MUTE_DELAY, TMODE_FAST_LOCK, TMODE_PHASE_ADJ, TMODE_OFF} timing_mode_t;

	typedef struct packed {
		logic             lock_speed_select;
		logic [1:0]       modulator_noise_mode;
		logic [2:0]       pin_select_low;
		logic             reference_doubler_enable;
		logic             reference_halve_enable;
		logic [9:0]       ref_divide;
		logic             buffered_update_enable;
		logic [3:0]       pump_current_code;
		logic             lock_function_select;
		logic             lock_window_select;
		logic             detector_polarity;
		logic             device_power_down;
		logic             pump_high_z;
		logic             counter_reset;
		logic [ADDR_W-1:0] addr;
	} ref_word_t;

	typedef struct packed {
		logic [5:0]       osc_select;
		logic             auto_select_disable;
		logic             auto_select_temp_comp;
		logic [4:0]       reserved;
		logic             cycle_slip_reduce;
		logic             lock_indicate_delay;
		logic [1:0]       timing_divider_mode;
		logic [11:0]      timing_divider_value;
		logic [ADDR_W-1:0] addr;
	} osc_word_t;

	localparam ref_word_t REF_WORD_RESET = ref_word_t'(32'h00004042);
	localparam osc_word_t OSC_WORD_RESET = osc_word_t'(32'h0000000B);

	typedef struct packed {
		logic        lock_speed_select;
		noise_mode_t noise_mode;
		logic        reference_doubler_enable;
		logic        reference_halve_enable;
		logic [9:0]  ref_divide;
		logic        buffered_update_enable;
		logic [3:0]  pump_current_code;
		logic [4:0]  pump_current_units;
		logic        lock_function_select;
		logic        lock_window_select;
		logic        detector_polarity;
		logic        device_power_down;
		logic        pump_high_z;
		logic        counter_reset;
	} ref_ctrl_t;

	typedef struct packed {
		logic [5:0]   manual_osc_select;
		logic         manual_osc_active;
		logic         auto_oscillator_select;
		logic         auto_select_temp_comp;
		logic         cycle_slip_reduce;
		logic         lock_indicate_delay;
		timing_mode_t timing_divider_mode;
		logic [11:0]  timing_divider_value;
	} osc_ctrl_t;

endpackage : synth_ctrl_pkg

// ===== hw/timing_divider.sv
`timescale 1ns/100ps
`default_nettype none

module timing_divider
(
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// control
	input  wire logic        enable_in,
	input  wire logic [11:0] divide_in,
	// tick
	output logic             tick_out
);
	import synth_ctrl_pkg::*;

	logic [11:0] count_r;

	// a zero divide is unused, so no tick is produced
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			count_r <= 12'h000;
			tick_out <= 1'b0;
		end
		else if (!enable_in || divide_in == 12'h000)
		begin
			count_r <= 12'h000;
			tick_out <= 1'b0;
		end
		else if (count_r >= divide_in - 12'h001)
		begin
			count_r <= 12'h000;
			tick_out <= 1'b1;
		end
		else
		begin
			count_r <= count_r + 12'h001;
			tick_out <= 1'b0;
		end
	end

endmodule : timing_divider

`default_nettype wire

// ===== bench/host_serial_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_serial_model
(
	// clock
	input  wire logic mclk_in,
	// serial programming port
	output var logic  ser_clk_out,
	output var logic  ser_data_out,
	output var logic  ser_load_out
);
	initial
	begin
		ser_clk_out = 1'b0;
		ser_data_out = 1'b0;
		ser_load_out = 1'b0;
	end

	// each clock level spans two mclk edges; the clock parks low between frames
	task automatic send_word(input logic [31:0] w);
		@(posedge mclk_in);
		#1;
		for (int i = 31; i >= 0; i--)
		begin
			ser_clk_out = 1'b0;
			ser_data_out = w[i];
			repeat (2) @(posedge mclk_in);
			#1;
			ser_clk_out = 1'b1;
			repeat (2) @(posedge mclk_in);
			#1;
		end
		ser_clk_out = 1'b0;
		// released data shows the inverse so a stale bit never passes as valid
		ser_data_out = ~w[0];
		repeat (2) @(posedge mclk_in);
		#1;
		ser_load_out = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		ser_load_out = 1'b0;
	endtask : send_word
endmodule : host_serial_model

`default_nettype wire

// ===== bench/synth_control_regs_two_three_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module synth_control_regs_two_three_monitor
	import synth_ctrl_pkg::*;
(
	input wire logic                      mclk_in,
	input wire logic                      rst_n_in,
	input wire logic                      mux_pin_in,
	input wire logic                      lock_indication_in,
	input wire logic                      mux_pin_oe_out,
	input wire synth_ctrl_pkg::ref_ctrl_t ref_ctrl_out,
	input wire synth_ctrl_pkg::osc_ctrl_t osc_ctrl_out,
	input wire logic                      mute_until_locked_out,
	input wire logic                      rf_mute_out,
	input wire logic                      timing_tick_out,
	input wire logic                      sync_out
);
	// decoded outputs settle one edge after release, so checking waits two
	logic [1:0] up_r;

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			up_r <= 2'h0;
		else
			up_r <= {up_r[0], 1'b1};
	end

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in || !up_r[1]);

	a_pump_units_sum: assert property (ref_ctrl_out.pump_current_units == {1'b0, ref_ctrl_out.pump_current_code} + 5'h1)
		else $error("pump units differ from code plus one");
	a_auto_vs_manual: assert property (osc_ctrl_out.auto_oscillator_select != osc_ctrl_out.manual_osc_active)
		else $error("auto select and manual select agree");
	a_sync_no_drive: assert property (sync_out |-> !mux_pin_oe_out)
		else $error("pin driven while used as sync input");
	a_sync_follows_pin: assert property (sync_out |-> $past(mux_pin_in))
		else $error("sync output without pin level");
	a_mute_off_idle: assert property (!mute_until_locked_out [*3] |-> !rf_mute_out)
		else $error("outputs muted with mute function off");
	a_lock_unmutes: assert property ((lock_indication_in && !osc_ctrl_out.lock_indicate_delay) [*3] |-> !rf_mute_out)
		else $error("mute kept despite undelayed lock");
	a_unlock_mutes: assert property ((mute_until_locked_out && !lock_indication_in) [*3] |-> rf_mute_out)
		else $error("outputs live without lock");
	a_delay_holds_mute: assert property (mute_until_locked_out && rf_mute_out && osc_ctrl_out.lock_indicate_delay
		&& osc_ctrl_out.timing_divider_mode == TMODE_MUTE_DELAY && $rose(lock_indication_in)
		|=> (rf_mute_out || !mute_until_locked_out) [*8])
		else $error("lock delay not applied");
	a_tick_single: assert property (timing_tick_out && osc_ctrl_out.timing_divider_value > 12'h1
		&& $stable(osc_ctrl_out) |=> !timing_tick_out)
		else $error("tick wider than one cycle");
	a_tick_off: assert property ((osc_ctrl_out.timing_divider_mode == TMODE_OFF
		|| osc_ctrl_out.timing_divider_value == 12'h0) [*3] |-> !timing_tick_out)
		else $error("tick while divider unused");

	c_tick: cover property (timing_tick_out);
	c_sync: cover property (sync_out);
	c_unmute: cover property ($fell(rf_mute_out));
endmodule : synth_control_regs_two_three_monitor

bind synth_control_regs_two_three synth_control_regs_two_three_monitor u_monitor
(
	.mclk_in, .rst_n_in, .mux_pin_in, .lock_indication_in, .mux_pin_oe_out, .ref_ctrl_out,
	.osc_ctrl_out, .mute_until_locked_out, .rf_mute_out, .timing_tick_out, .sync_out
);

`default_nettype wire

// ===== bench/synth_control_regs_two_three_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module synth_control_regs_two_three_tb_top;
	import synth_ctrl_pkg::*;

	logic mclk_in, rst_n_in, ser_clk, ser_data, ser_load, mux_pin_in, mux_msb_in, ref_div_in, fb_div_in;
	logic analog_lock_in, lock_indication_in, mux_pin_out, mux_pin_oe_out, mute_until_locked_out;
	logic rf_mute_out, timing_tick_out, sync_out, mu;
	logic [31:0] readback_word_in, w2, w3, w;
	logic [2:0] out_div_ratio_out, div_a, div_p;
	logic [9:0] rdiv_a;
	logic [3:0] cp_a;
	ref_ctrl_t ref_ctrl_out;
	osc_ctrl_t osc_ctrl_out;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	integer seed = 78;

	initial
	begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	host_serial_model u_host_serial_model (.mclk_in, .ser_clk_out(ser_clk), .ser_data_out(ser_data),
		.ser_load_out(ser_load));
	synth_control_regs_two_three u_synth_control_regs_two_three (.mclk_in, .rst_n_in, .ser_clk_in(ser_clk),
		.ser_data_in(ser_data), .ser_load_in(ser_load), .mux_pin_in, .mux_pin_out, .mux_pin_oe_out, .mux_msb_in,
		.ref_div_in, .fb_div_in, .analog_lock_in, .lock_indication_in, .readback_word_in, .ref_ctrl_out,
		.osc_ctrl_out, .out_div_ratio_out, .mute_until_locked_out, .rf_mute_out, .timing_tick_out, .sync_out);

	function automatic logic [30:0] exp_ref();
		logic [1:0] nm;
		nm = (w2[30:29] == 2'h3) ? 2'h2 : {1'b0, w2[30:29] == 2'h2};
		return {w2[31], nm, w2[25:24], rdiv_a, w2[13], cp_a, {1'b0, cp_a} + 5'h1, w2[8:3]};
	endfunction : exp_ref

	function automatic logic [24:0] exp_osc();
		return {w3[31:26], w3[25], ~w3[25], w3[24], w3[18:15], w3[14:3]};
	endfunction : exp_osc

	// halved feedback flips on each rising edge of the divider output
	logic fb_h = 1'b0;
	always @(posedge fb_div_in) fb_h = ~fb_h;

	// {drive enable, level}
	function automatic logic [1:0] exp_mux(input logic [3:0] c);
		case (c)
			4'h1: return 2'h3;
			4'h2: return 2'h2;
			4'h3: return {1'b1, ref_div_in};
			4'h4: return {1'b1, fb_h};
			4'h5: return {1'b1, analog_lock_in};
			4'h6: return {1'b1, lock_indication_in};
			4'hC: return {1'b1, readback_word_in[31]};
			default: return 2'h0;
		endcase
	endfunction : exp_mux

	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		n_checks++;
		if (a !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t: got %h expected %h", $time, a, e);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// manual select is only meaningful while auto selection is off
	task automatic chk_ctrl();
		logic [31:0] om;
		om = {7'h0, {6{w3[25]}}, 19'h7FFFF};
		chk(32'(ref_ctrl_out), 32'(exp_ref()));
		chk(32'(osc_ctrl_out) & om, 32'(exp_osc()) & om);
		chk(32'(out_div_ratio_out), 32'(div_a));
		chk(32'(mute_until_locked_out), 32'(mu));
	endtask : chk_ctrl

	task automatic wr(input logic [31:0] v);
		u_host_serial_model.send_word(v);
		case (v[2:0])
			ADDR_REG0:
			begin
				if (w2[23:14] != 10'h0)
					rdiv_a = w2[23:14];
				cp_a = w2[12:9];
				div_a = div_p;
			end
			ADDR_REG2: w2 = v;
			ADDR_REG3: w3 = v;
			ADDR_REG4:
			begin
				div_p = v[22:20];
				mu = v[10];
				if (!w2[13])
					div_a = div_p;
			end
			default: ;
		endcase
		repeat (2) @(posedge mclk_in);
		#1;
		chk_ctrl();
	endtask : wr

	task automatic mute_chk(input int n, input logic e);
		repeat (n) @(posedge mclk_in);
		#1;
		chk(32'(rf_mute_out), 32'(e));
	endtask : mute_chk

	task automatic cnt(input int n, input int e);
		int k;
		k = 0;
		repeat (n)
		begin
			@(posedge mclk_in);
			#1;
			if (timing_tick_out === 1'b1)
				k++;
		end
		chk(32'(k), 32'(e));
	endtask : cnt

	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	initial
	begin
		{rst_n_in, mux_pin_in, mux_msb_in, ref_div_in, fb_div_in, analog_lock_in, lock_indication_in} = 7'h0;
		readback_word_in = 32'h0;
		w2 = 32'h0000_4042;
		w3 = 32'h0000_000B;
		{rdiv_a, cp_a, div_a, div_p, mu} = {10'h1, 4'h0, 3'h0, 3'h0, 1'b0};
		repeat (5) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		chk_ctrl();
		wr(32'h00FF_C002);
		wr(32'h0000_0000);
		wr(32'h0000_2002);
		wr(32'h0000_0000);
		wr(32'h0050_0004);
		wr(32'h0000_0000);
		wr(32'h0000_0002);
		wr(32'h0030_0004);
		repeat (40)
		begin
			w = $random(seed);
			{lock_indication_in, mux_pin_in} = 2'($random(seed));
			if (w[2:0] == 3'h2 && w[30:29] == 2'h1)
				w[29] = 1'b0;
			if (w[2:0] == 3'h3)
				w[23:15] = {5'h0, w[16:15] == 2'h3 ? 2'h0 : w[18:17], w[16], w[15] & ~w[16]};
			wr(w);
		end
		for (int c = 0; c < 16; c++)
		begin
			{mux_msb_in, ref_div_in, fb_div_in, analog_lock_in, lock_indication_in, mux_pin_in} =
				{c[3], 5'($random(seed))};
			readback_word_in = $random(seed);
			w = {w2[31:29], c[2:0], w2[25:3], 3'h2};
			wr(w);
			wr(w);
			chk({30'h0, mux_pin_oe_out, mux_pin_out & mux_pin_oe_out}, 32'(exp_mux(4'(c))));
			chk(32'(sync_out), 32'((c == 7) & mux_pin_in));
		end
		{mux_msb_in, lock_indication_in} = 2'h0;
		wr(32'h0000_0013);
		wr(32'h0000_0404);
		mute_chk(1, 1'b1);
		lock_indication_in = 1'b1;
		mute_chk(3, 1'b0);
		lock_indication_in = 1'b0;
		wr(32'h0002_0013);
		mute_chk(1, 1'b1);
		lock_indication_in = 1'b1;
		mute_chk(8, 1'b1);
		mute_chk(60, 1'b0);
		for (int m = 0; m < 4; m++)
		begin
			wr({15'h0, 2'(m), 12'h5, 3'h3});
			cnt(50, m == 3 ? 0 : 10);
		end
		wr(32'h0000_800B);
		cnt(50, 50);
		wr(32'h0000_8003);
		cnt(50, 0);
		finish_test();
	end
endmodule : synth_control_regs_two_three_tb_top

`default_nettype wire
